// [src/gdrt_top.sv]
/*
 Gate, delay and reference timing block: APB control latches, 24-bit mode shift chain, 1 kHz reference
 divider with resynchronisation, and the delayed or free internal gate generator.
 Assumes a 10 MHz clock on mclk_in, a synchronous active-high reset and an external comparator input
 already synchronous to that clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gdrt_map.svh"
module gdrt_top #(
  parameter int REF_DIV = `GDRT_REF_DIV
) (
  // Clock and reset.
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // APB slave.
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // External trigger.
  input  wire logic        ext_comparator_in,
  // Converter and voltmeter control.
  output logic [2:0]       ain_sel_out,
  output logic             voltmeter_sample_n_out,
  output logic             voltmeter_range_high_out,
  output logic             meter_src1_sel_out,
  output logic             meter_src1_sel_n_out,
  output logic [2:0]       aout_sel_out,
  output logic             aout_connect_out,
  output logic             timebase_ext_out,
  output logic             ref_ttl_out,
  // Mode bits, reference and gate.
  output logic [23:0]      mode_bits_out,
  output logic             ref_1khz_out,
  output logic             cal_trigger_out,
  output logic             rt_tick_out,
  output logic             gate_ctrl_out,
  output logic             delay_done_n_out
);
  logic [7:0]  conv_q, conv_d, misc_q, misc_d;
  logic [23:0] chain_q, chain_d, mode_q, mode_d;
  logic [15:0] pre_div_q, pre_div_d, width_q, width_d, delay_q, delay_d;
  logic        run_n_q, run_n_d, delayed_q, delayed_d, trig_pulse;
  logic        acc, wr, rd_ok;
  logic [31:0] rdata_d, rdata_q;
  assign acc = psel_in && penable_in;
  assign wr  = acc && pwrite_in;
  always_comb begin
    rd_ok = 1'b1;
    rdata_d = 32'h0;
    case (paddr_in)
      `GDRT_OFF_CONV:     rdata_d = {24'h0, conv_q};
      `GDRT_OFF_MISC:     rdata_d = {24'h0, misc_q};
      `GDRT_OFF_SHIFT:    rdata_d = 32'h0;
      `GDRT_OFF_LOAD:     rdata_d = 32'h0;
      `GDRT_OFF_PRESCALE: rdata_d = {16'h0, pre_div_q};
      `GDRT_OFF_WIDTH:    rdata_d = {width_q, delay_q};
      `GDRT_OFF_GATECMD:  rdata_d = {29'h0, delayed_q, 1'b0, run_n_q};
      `GDRT_OFF_STATUS:   rdata_d = 32'h0;
      `GDRT_OFF_MODE:     rdata_d = {8'h0, mode_q};
      default:            rd_ok = 1'b0;
    endcase
  end
  // Zero-wait APB: answer in the access cycle; data are registered below through the address read mux.
  assign pready_out  = 1'b1;
  assign pslverr_out = acc && !rd_ok;
  assign prdata_out  = rdata_q;

  always_comb begin
    conv_d = conv_q;
    misc_d = misc_q;
    chain_d = chain_q;
    mode_d = mode_q;
    pre_div_d = pre_div_q;
    width_d = width_q;
    delay_d = delay_q;
    run_n_d = run_n_q;
    delayed_d = delayed_q;
    trig_pulse = 1'b0;
    if (wr) begin
      case (paddr_in)
        `GDRT_OFF_CONV:     conv_d = pwdata_in[7:0];
        `GDRT_OFF_MISC:     misc_d = pwdata_in[7:0];
        `GDRT_OFF_SHIFT:    chain_d = {chain_q[22:0], pwdata_in[7]};
        `GDRT_OFF_LOAD:     mode_d = chain_q;
        `GDRT_OFF_PRESCALE: pre_div_d = pwdata_in[15:0];
        `GDRT_OFF_WIDTH: begin
          width_d = pwdata_in[31:16];
          delay_d = pwdata_in[15:0];
        end
        `GDRT_OFF_GATECMD: begin
          run_n_d = pwdata_in[`GDRT_CMD_RUN_BIT];
          delayed_d = pwdata_in[`GDRT_CMD_DELAY_BIT];
          trig_pulse = pwdata_in[`GDRT_CMD_TRIG_BIT];
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      conv_q <= `GDRT_CONV_RESET;
      misc_q <= `GDRT_MISC_RESET;
      chain_q <= 24'h0;
      mode_q <= 24'h0;
      pre_div_q <= `GDRT_PRESCALE_RST;
      width_q <= 16'h0001;
      delay_q <= 16'h0001;
      run_n_q <= 1'b1;
      delayed_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      conv_q <= conv_d;
      misc_q <= misc_d;
      chain_q <= chain_d;
      mode_q <= mode_d;
      pre_div_q <= pre_div_d;
      width_q <= width_d;
      delay_q <= delay_d;
      run_n_q <= run_n_d;
      delayed_q <= delayed_d;
      rdata_q <= rdata_d;
    end
  end

  assign ain_sel_out = conv_q[2:0];
  assign voltmeter_sample_n_out = conv_q[`GDRT_CONV_SH_BIT];
  assign voltmeter_range_high_out = conv_q[`GDRT_CONV_GAIN_BIT];
  assign meter_src1_sel_out = conv_q[`GDRT_CONV_SRC_BIT];
  assign meter_src1_sel_n_out = conv_q[`GDRT_CONV_SRCN_BIT];
  assign aout_sel_out = misc_q[2:0];
  assign aout_connect_out = !misc_q[`GDRT_MISC_INH_BIT];
  assign timebase_ext_out = misc_q[`GDRT_MISC_CLK_BIT];
  assign ref_ttl_out = misc_q[`GDRT_MISC_TTL_BIT];
  assign mode_bits_out = mode_q;

  // Reference chain: 5 MHz phase toggle, divide by REF_DIV into a square wave.
  logic        ph_q, ph_d, sq_q, sq_d, r5_q, r5_d, r10_q, r10_d, tick_q, tick_d;
  logic [12:0] rc_q, rc_d;
  always_comb begin
    ph_d = !ph_q;
    rc_d = rc_q;
    sq_d = sq_q;
    r5_d = r5_q;
    tick_d = 1'b0;
    if (ph_q) begin
      if (rc_q == 13'(REF_DIV / 2 - 1)) begin
        rc_d = 13'h0;
        sq_d = !sq_q;
        tick_d = !sq_q;
      end else begin
        rc_d = rc_q + 13'h1;
      end
      r5_d = sq_q;
    end
    r10_d = r5_q;
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ph_q <= 1'b0;
      rc_q <= 13'h0;
      sq_q <= 1'b0;
      r5_q <= 1'b0;
      r10_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      rc_q <= rc_d;
      sq_q <= sq_d;
      r5_q <= r5_d;
      r10_q <= r10_d;
      tick_q <= tick_d;
    end
  end
  assign ref_1khz_out = r10_q;
  assign cal_trigger_out = r10_q;
  assign rt_tick_out = tick_q;

  // Gate generator.
  logic       ext_q, cap_q, cap_d, half_q, half_d, pclk_q, pclk_d;
  logic       gate_q, gate_d, dn_q, dn_d;
  logic [15:0] pc_q, pc_d, wc_q, wc_d;
  gdrt_pkg::gdrt_gate_t st_q, st_d;
  logic       rise, fall;
  assign rise = ext_comparator_in && !ext_q;
  assign fall = !ext_comparator_in && ext_q;
  always_comb begin
    cap_d = cap_q;
    if (!run_n_q) begin
      cap_d = 1'b1;
    end else if ((rise && misc_q[`GDRT_MISC_RISE_BIT]) || (fall && misc_q[`GDRT_MISC_FALL_BIT])) begin
      cap_d = 1'b1;
    end else if (trig_pulse) begin
      cap_d = 1'b0;
    end
    half_d = cap_q ? !half_q : 1'b0;
    pc_d = pc_q;
    pclk_d = 1'b0;
    // A trigger restarts the prescaler, so a tick left over from an earlier run cannot end a new delay early.
    if (!cap_q || trig_pulse) begin
      pc_d = 16'h0;
    end else if (half_q) begin
      if (pc_q + 16'h1 >= pre_div_q) begin
        pc_d = 16'h0;
        pclk_d = 1'b1;
      end else begin
        pc_d = pc_q + 16'h1;
      end
    end
    st_d = st_q;
    wc_d = wc_q;
    gate_d = gate_q;
    dn_d = 1'b1;
    case (st_q)
      gdrt_pkg::GDRT_IDLE: begin
        gate_d = 1'b0;
        if (trig_pulse) begin
          wc_d = delayed_d ? delay_d : width_d;
          st_d = delayed_d ? gdrt_pkg::GDRT_DELAY : gdrt_pkg::GDRT_OPEN;
        end
      end
      gdrt_pkg::GDRT_DELAY: begin
        if (pclk_q) begin
          if (wc_q <= 16'h1) begin
            dn_d = 1'b0;
            wc_d = width_q;
            st_d = gdrt_pkg::GDRT_OPEN;
          end else begin
            wc_d = wc_q - 16'h1;
          end
        end
      end
      gdrt_pkg::GDRT_OPEN: begin
        if (pclk_q) begin
          gate_d = (wc_q != 16'h0);
          if (wc_q == 16'h0) begin
            st_d = gdrt_pkg::GDRT_IDLE;
          end else begin
            wc_d = wc_q - 16'h1;
          end
        end
      end
      default: st_d = gdrt_pkg::GDRT_IDLE;
    endcase
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ext_q <= 1'b0;
      cap_q <= 1'b0;
      half_q <= 1'b0;
      pclk_q <= 1'b0;
      pc_q <= 16'h0;
      wc_q <= 16'h0;
      st_q <= gdrt_pkg::GDRT_IDLE;
      gate_q <= 1'b0;
      dn_q <= 1'b1;
    end else begin
      ext_q <= ext_comparator_in;
      cap_q <= cap_d;
      half_q <= half_d;
      pclk_q <= pclk_d;
      pc_q <= pc_d;
      wc_q <= wc_d;
      st_q <= st_d;
      gate_q <= gate_d;
      dn_q <= dn_d;
    end
  end
  assign gate_ctrl_out = gate_q && conv_q[`GDRT_CONV_GATE_BIT];
  assign delay_done_n_out = dn_q;

  // Control latches: every CONV and MISC field follows the word written in the previous access cycle; the mode bits follow the shift chain.
  conv_bits_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $past(wr) && $past(paddr_in) == `GDRT_OFF_CONV |-> ain_sel_out == $past(pwdata_in[2:0]))
    else $error("input select not loaded");
  sample_cmd_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $past(wr) && $past(paddr_in) == `GDRT_OFF_CONV |-> voltmeter_sample_n_out == $past(pwdata_in[3]))
    else $error("sample command wrong");
  range_sel_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $past(wr) && $past(paddr_in) == `GDRT_OFF_CONV |-> voltmeter_range_high_out == $past(pwdata_in[4]))
    else $error("range not loaded");
  gate_enable_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !conv_q[7] |-> !gate_ctrl_out) else $error("gate open while disabled");
  inhibit_off_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    misc_q[3] |-> !aout_connect_out) else $error("output connected under inhibit");
  aout_sel_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $past(wr) && $past(paddr_in) == `GDRT_OFF_MISC |->
      {aout_connect_out, aout_sel_out} == {!$past(pwdata_in[3]), $past(pwdata_in[2:0])})
    else $error("output select not loaded");
  timebase_sel_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $past(wr) && $past(paddr_in) == `GDRT_OFF_MISC |-> timebase_ext_out == $past(pwdata_in[5]))
    else $error("timebase source not loaded");
  ref_level_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $past(wr) && $past(paddr_in) == `GDRT_OFF_MISC |-> ref_ttl_out == $past(pwdata_in[6]))
    else $error("reference level not loaded");
  shift_in_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $past(wr) && $past(paddr_in) == `GDRT_OFF_SHIFT |-> chain_q == {$past(chain_q[22:0]), $past(pwdata_in[7])})
    else $error("mode bit not shifted");
  mode_load_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $past(wr) && $past(paddr_in) == `GDRT_OFF_LOAD |-> mode_bits_out == $past(chain_q))
    else $error("mode bits not transferred");
  // Reference chain.
  ref_half_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    sq_q != $past(sq_q) |-> $past(ph_q) && $past(rc_q) == 13'(REF_DIV / 2 - 1))
    else $error("reference toggled off count");
  tick_once_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    rt_tick_out |=> !rt_tick_out [*8]) else $error("tick repeats");
  tick_rise_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    rt_tick_out |-> sq_q && !$past(sq_q)) else $error("tick not on reference rise");
  ref_retime_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ref_1khz_out == $past(r5_q)) else $error("reference not retimed");
  // Gate generator.
  run_preset_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !run_n_q |=> cap_q) else $error("clock-run did not preset");
  run_clock_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !cap_q |=> !half_q) else $error("divider ran without capture");
  prescale_tick_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    pclk_q |-> $past(cap_q) && !$past(trig_pulse)) else $error("stray prescaled tick");
  ext_edge_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    rise && misc_q[4] && !trig_pulse |=> cap_q) else $error("edge not captured");
  trig_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    trig_pulse && run_n_q && !rise && !fall |=> !cap_q) else $error("capture not rearmed");
  delay_start_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $past(trig_pulse) && $past(delayed_d) && $past(st_q) == gdrt_pkg::GDRT_IDLE |-> st_q == gdrt_pkg::GDRT_DELAY)
    else $error("delay not started");
  delay_count_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q == gdrt_pkg::GDRT_DELAY && pclk_q && wc_q > 16'h1 |=> st_q == gdrt_pkg::GDRT_DELAY && wc_q == $past(wc_q) - 16'h1)
    else $error("delay count wrong");
  delay_pulse_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !delay_done_n_out |=> delay_done_n_out) else $error("delay pulse too long");
  delay_open_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !delay_done_n_out |-> st_q == gdrt_pkg::GDRT_OPEN) else $error("gate not opened after delay");
  open_count_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q == gdrt_pkg::GDRT_OPEN && pclk_q && wc_q != 16'h0 |=> gate_q && wc_q == $past(wc_q) - 16'h1)
    else $error("width count wrong");
  gate_step_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    gate_q != $past(gate_q) |-> $past(pclk_q)) else $error("gate moved off prescaled clock");
  idle_closed_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q == gdrt_pkg::GDRT_IDLE |-> !gate_q) else $error("gate open while idle");
  // Main scenarios that the bench should reach.
  gate_opened_c: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(gate_ctrl_out));
  delayed_c: cover property (@(posedge mclk_in) disable iff (rst_in) $fell(delay_done_n_out));
  ref_c: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(ref_1khz_out));
  edge_arm_c: cover property (@(posedge mclk_in) disable iff (rst_in) trig_pulse && delayed_d ##1 !cap_q);
endmodule : gdrt_top
`default_nettype wire

// [src/gdrt_map.svh]
/*
 Register offsets, field positions, reset values and timing counts of the gate, delay and reference timing block.
 Assumes it is included by bare name inside a source file of this block.
*/
`ifndef GDRT_MAP_SVH
`define GDRT_MAP_SVH
`define GDRT_OFF_CONV     12'h000
`define GDRT_OFF_MISC     12'h004
`define GDRT_OFF_SHIFT    12'h008
`define GDRT_OFF_LOAD     12'h00C
`define GDRT_OFF_PRESCALE 12'h010
`define GDRT_OFF_WIDTH    12'h014
`define GDRT_OFF_GATECMD  12'h018
`define GDRT_OFF_STATUS   12'h01C
`define GDRT_OFF_MODE     12'h020
`define GDRT_CONV_SH_BIT   3
`define GDRT_CONV_GAIN_BIT 4
`define GDRT_CONV_SRC_BIT  5
`define GDRT_CONV_SRCN_BIT 6
`define GDRT_CONV_GATE_BIT 7
`define GDRT_MISC_INH_BIT  3
`define GDRT_MISC_RISE_BIT 4
`define GDRT_MISC_CLK_BIT  5
`define GDRT_MISC_TTL_BIT  6
`define GDRT_MISC_FALL_BIT 7
`define GDRT_CMD_RUN_BIT   0
`define GDRT_CMD_TRIG_BIT  1
`define GDRT_CMD_DELAY_BIT 2
`define GDRT_CONV_RESET    8'h58
`define GDRT_MISC_RESET    8'h08
`define GDRT_MODE_BITS     24
`define GDRT_REF_DIV       5000
`define GDRT_PRESCALE_RST  16'h0064
`endif

// [src/gdrt_pkg.sv]
/*
 Types of the gate, delay and reference timing block.
 Assumes nothing of its surroundings.
*/
package gdrt_pkg;
  typedef enum logic [2:0] {
    GDRT_IDLE  = 3'b001,
    GDRT_DELAY = 3'b010,
    GDRT_OPEN  = 3'b100
  } gdrt_gate_t;
endpackage : gdrt_pkg

// [test/gdrt_host.sv]
/*
 APB master model of the host processor that programs the gate, delay and reference timing block.
 Assumes one clock shared with the block and a slave that may stretch the access phase.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gdrt_map.svh"
module gdrt_host (
  // Clock.
  input  wire logic        mclk_in,
  // APB master side.
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [11:0]      paddr_out,
  output logic [31:0]      pwdata_out,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in
);
  initial begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 12'h000;
    pwdata_out  = 32'h00000000;
  end

  // The request is held until pready is seen high; the bench watchdog ends a slave that never answers.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge mclk_in);
    psel_out    <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out  <= wr;
    paddr_out   <= a;
    pwdata_out  <= d;
    @(posedge mclk_in);
    penable_out <= 1'b1;
    @(posedge mclk_in);
    while (pready_in !== 1'b1) @(posedge mclk_in);
    rd  = prdata_in;
    err = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
  endtask : xfer

  // Mode bits go most significant first; nothing reaches the outputs until the load strobe.
  task automatic shift_bits(input logic [23:0] v);
    logic [31:0] rd;
    logic        err;
    for (int i = 23; i >= 0; i--) begin
      xfer(1'b1, `GDRT_OFF_SHIFT, {24'h000000, v[i], 7'h00}, rd, err);
    end
  endtask : shift_bits
endmodule : gdrt_host
`default_nettype wire

// [test/gate_delay_reference_timing_tb.sv]
/*
 Self-checking testbench of the gate, delay and reference timing block.
 Assumes the host model in gdrt_host.sv and a shortened reference divider.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gdrt_map.svh"
module gate_delay_reference_timing_tb;
  localparam int DIV = 10;
  logic        mclk_in, rst_in, psel, penable, pwrite, pready, pslverr, err, ext_cmp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  ain_sel, aout_sel;
  logic [23:0] mode_bits;
  logic        smp_n, rng, src, src_n, connect, tb_ext, ttl, ref_clk, cal, tick, gate, done_n;
  int          err_count, n_tests, k, t, c;

  gdrt_top #(.REF_DIV(DIV)) DUT (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .ext_comparator_in(ext_cmp), .ain_sel_out(ain_sel), .voltmeter_sample_n_out(smp_n),
    .voltmeter_range_high_out(rng), .meter_src1_sel_out(src), .meter_src1_sel_n_out(src_n),
    .aout_sel_out(aout_sel), .aout_connect_out(connect), .timebase_ext_out(tb_ext), .ref_ttl_out(ttl),
    .mode_bits_out(mode_bits), .ref_1khz_out(ref_clk), .cal_trigger_out(cal), .rt_tick_out(tick),
    .gate_ctrl_out(gate), .delay_done_n_out(done_n));
  gdrt_host host (.mclk_in(mclk_in), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));

  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
    @(negedge mclk_in);
    @(negedge mclk_in);
  endtask : wr

  // Waits for the gate to open, then checks how many cycles it stayed open against exp.
  task automatic gate_len(input logic [31:0] exp);
    int w;
    w = 0;
    for (int i = 0; i < 300 && gate !== 1'b1; i++) @(negedge mclk_in);
    while (gate === 1'b1 && w < 1000) begin
      w++;
      @(negedge mclk_in);
    end
    chk(w, exp);
  endtask : gate_len

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  initial begin
    #(25 * 20000);
    err_count++;
    final_report();
  end

  initial begin
    err_count = 0;
    n_tests   = 0;
    rst_in    = 1'b1;
    ext_cmp   = 1'b0;
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(negedge mclk_in);
    chk({src_n, src, rng, smp_n, ain_sel, connect, gate, done_n}, 32'h000002C1);
    chk(mode_bits, 32'h0);
    wr(`GDRT_OFF_CONV, 32'hB5);
    chk({src_n, src, rng, smp_n, ain_sel}, 32'h35);
    wr(`GDRT_OFF_CONV, 32'h4A);
    chk({src_n, src, rng, smp_n, ain_sel}, 32'h4A);
    for (int a = 0; a < 8; a++) begin
      wr(`GDRT_OFF_MISC, 32'h08 | a);
      chk({connect, aout_sel}, a);
      wr(`GDRT_OFF_MISC, {24'h0, 1'b0, a[0], a[1], 2'b00, a[2:0]});
      chk({connect, ttl, tb_ext, aout_sel}, {26'h0, 1'b1, a[0], a[1], a[2:0]});
    end
    host.xfer(1'b1, 12'h040, 32'hFF, rd, err);
    chk(err, 1'b1);
    host.shift_bits(24'hA53C96);
    @(negedge mclk_in);
    chk(mode_bits, 32'h0);
    wr(`GDRT_OFF_LOAD, 32'h1);
    chk(mode_bits, 32'hA53C96);
    host.xfer(1'b0, `GDRT_OFF_MODE, 32'h0, rd, err);
    chk(rd, 32'hA53C96);
    for (int i = 0; i < 100 && ref_clk !== 1'b0; i++) @(negedge mclk_in);
    for (int i = 0; i < 100 && ref_clk !== 1'b1; i++) @(negedge mclk_in);
    k = 0;
    c = 0;
    do begin
      @(negedge mclk_in);
      k++;
      c += (cal !== ref_clk);
    end while (ref_clk === 1'b1 && k < 100);
    do begin
      @(negedge mclk_in);
      k++;
      c += (cal !== ref_clk);
    end while (ref_clk === 1'b0 && k < 100);
    chk(k, 2 * DIV);
    chk(c, 0);
    t = 0;
    for (int i = 0; i < 6 * DIV; i++) begin
      @(negedge mclk_in);
      t += (tick === 1'b1);
    end
    chk(t, 3);
    wr(`GDRT_OFF_PRESCALE, 32'd5);
    wr(`GDRT_OFF_WIDTH, {16'd2, 16'd2});
    wr(`GDRT_OFF_CONV, 32'hD8);
    wr(`GDRT_OFF_GATECMD, 32'h2);
    gate_len(2 * 2 * 5);
    wr(`GDRT_OFF_CONV, 32'h58);
    wr(`GDRT_OFF_GATECMD, 32'h2);
    gate_len(0);
    wr(`GDRT_OFF_CONV, 32'hD8);
    wr(`GDRT_OFF_GATECMD, 32'h1);
    for (int e = 0; e < 2; e++) begin
      wr(`GDRT_OFF_MISC, e ? 32'h88 : 32'h18);
      wr(`GDRT_OFF_GATECMD, 32'h7);
      @(posedge mclk_in);
      ext_cmp <= ~ext_cmp;
      for (int i = 0; i < 300 && done_n !== 1'b0; i++) @(negedge mclk_in);
      k = 0;
      while (done_n === 1'b0 && k < 10) begin
        k++;
        @(negedge mclk_in);
      end
      chk(k, 1);
      gate_len(2 * 2 * 5);
    end
    final_report();
  end
endmodule : gate_delay_reference_timing_tb
`default_nettype wire
